//--- rtl/ramp_flags_defs.svh
// Purpose: constants for the ramp status and event flag block
// Assumes: included by bare name
// Notes:   bit positions of the event clear and flag vectors
`ifndef RAMP_FLAGS_DEFS_SVH
`define RAMP_FLAGS_DEFS_SVH
`define EVT_POS_BIT   0
`define EVT_STALL_BIT 1
`define EVT_COUNT     2
`define SPEED_W       23
`define POS_W         32
`endif

//--- rtl/ramp_flags_pkg.sv
// Purpose: types for the ramp status and event flag block
// Assumes: defs header holds the numbers
// Notes:   one type for the event vector
`include "ramp_flags_defs.svh"
package ramp_flags_pkg;
  typedef logic [`EVT_COUNT-1:0] event_vec_type; // one bit per event
  typedef enum logic [1:0]
  {
    STALL_RUN  = 2'b01,
    STALL_HELD = 2'b10
  } stall_state_type;
endpackage : ramp_flags_pkg

//--- rtl/equal_compare.sv
// Purpose: registered equality detector
// Assumes: both operands synchronous to sys_clk
// Notes:   output is a level, one cycle after its operands
`timescale 1ns/1ns
`default_nettype none
module equal_compare #(
  parameter int WIDTH = 32
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] lhs,
  input  wire logic [WIDTH-1:0] rhs,
  output var  logic             match
);
  initial
  begin
    if (WIDTH < 1) $error("width must be positive");
  end

  // match follows equality; falls one cycle after it breaks
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      match <= 1'b0;
    else
      match <= (lhs == rhs);
  end
endmodule : equal_compare
`default_nettype wire

//--- rtl/ramp_status_event_flags.sv
// Purpose: level and sticky event flags of the ramp generator
// Assumes: inputs synchronous to sys_clk; clear strobes are one-cycle
// Notes:   a set in the same cycle as its clear wins over the clear
`include "ramp_flags_defs.svh"
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - velocity flag high while speed equals maximum
// - position flag high while position equals goal
// - arrival event sets on position flag rise
// - writing one clears arrival event and interrupt
// - clearing stall event releases stall stop
// - writing one clears stall event and interrupt
// - interrupt is OR of event flags
// - stall detection stop sets stall event
module ramp_status_event_flags #(
  parameter int SPEED_W = `SPEED_W,
  parameter int POS_W   = `POS_W
) (
  input  wire logic                          sys_clk,
  input  wire logic                          rst_n,
  input  wire logic [SPEED_W-1:0]            current_ramp_speed,
  input  wire logic [SPEED_W-1:0]            max_ramp_speed,
  input  wire logic [POS_W-1:0]              current_motor_position,
  input  wire logic [POS_W-1:0]              goal_position,
  input  wire logic                          stall_detect,
  input  wire ramp_flags_pkg::event_vec_type event_clear,
  output var  logic                          velocity_reached,
  output var  logic                          position_reached,
  output var  logic                          pos_arrival_event_flag,
  output var  logic                          stall_stop_event_flag,
  output var  logic                          stall_stop_active,
  output var  logic                          irq_out
);
  import ramp_flags_pkg::*;

  initial
  begin
    if (SPEED_W < 1 || POS_W < 1) $error("widths must be positive");
  end

  logic            position_prev;  // last position flag, for rise detect
  logic            pos_rise;       // arrival event trigger
  logic            clr_pos;        // host clear of arrival event
  logic            clr_stall;      // host clear of stall event
  logic            next_pos_evt;   // next arrival flag
  logic            next_stall_evt; // next stall flag
  stall_state_type stall_state;    // stall stop state
  stall_state_type next_stall_state; // next stall stop state

  // speed equality detector
  equal_compare #(.WIDTH(SPEED_W)) u_speed_eq (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .lhs     (current_ramp_speed),
    .rhs     (max_ramp_speed),
    .match   (velocity_reached)
  );

  // position equality detector
  equal_compare #(.WIDTH(POS_W)) u_pos_eq (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .lhs     (current_motor_position),
    .rhs     (goal_position),
    .match   (position_reached)
  );

  assign clr_pos   = event_clear[`EVT_POS_BIT];
  assign clr_stall = event_clear[`EVT_STALL_BIT];
  assign pos_rise  = position_reached & ~position_prev;

  // next values: set beats clear
  always_comb
  begin
    next_pos_evt   = (pos_arrival_event_flag & ~clr_pos)
                   | pos_rise;
    next_stall_evt = (stall_stop_event_flag & ~clr_stall)
                   | stall_detect;
  end

  // edge history of position flag
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      position_prev <= 1'b0;
    else
      position_prev <= position_reached;
  end

  // sticky arrival event
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      pos_arrival_event_flag <= 1'b0;
    else
      pos_arrival_event_flag <= next_pos_evt;
  end

  // sticky stall event
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      stall_stop_event_flag <= 1'b0;
    else
      stall_stop_event_flag <= next_stall_evt;
  end

  // stall stop holds the motor until the event is cleared
  always_comb
  begin
    next_stall_state = stall_state;
    case (stall_state)
      STALL_RUN:
        if (stall_detect)
          next_stall_state = STALL_HELD;
      STALL_HELD:
        if (clr_stall && !stall_detect)
          next_stall_state = STALL_RUN;
      default:
        next_stall_state = STALL_RUN;
    endcase
  end

  // stall stop state register
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      stall_state <= STALL_RUN;
    else
      stall_state <= next_stall_state;
  end

  // registered stop output, mirrors next state
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      stall_stop_active <= 1'b0;
    else
      stall_stop_active <= (next_stall_state == STALL_HELD);
  end

  // interrupt is the OR of the next event flags, so it tracks them
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      irq_out <= 1'b0;
    else
      irq_out <= next_pos_evt | next_stall_evt;
  end

  // checks; the velocity and position level checks skip the first edge after reset, which still
  // shows the reset value of the registered flags
  property p_vel;
    @(posedge sys_clk) disable iff (!rst_n)
    $past(rst_n)
      |-> velocity_reached == $past(current_ramp_speed == max_ramp_speed);
  endproperty
  a_vel: assert property (p_vel) else $error("velocity flag wrong");

  property p_pos;
    @(posedge sys_clk) disable iff (!rst_n)
    $past(rst_n)
      |-> position_reached == $past(current_motor_position == goal_position);
  endproperty
  a_pos: assert property (p_pos) else $error("position flag wrong");

  property p_arr_set;
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(position_reached) |=> pos_arrival_event_flag;
  endproperty
  a_arr_set: assert property (p_arr_set) else $error("arrival lost");

  property p_arr_clr;
    @(posedge sys_clk) disable iff (!rst_n)
    (clr_pos && !pos_rise) |=> !pos_arrival_event_flag;
  endproperty
  a_arr_clr: assert property (p_arr_clr) else $error("arrival stuck");

  property p_arr_hold;
    @(posedge sys_clk) disable iff (!rst_n)
    (pos_arrival_event_flag && !clr_pos) |=> pos_arrival_event_flag;
  endproperty
  a_arr_hold: assert property (p_arr_hold) else $error("arrival drop");

  property p_stall_set;
    @(posedge sys_clk) disable iff (!rst_n)
    stall_detect |=> stall_stop_event_flag && stall_stop_active;
  endproperty
  a_stall_set: assert property (p_stall_set) else $error("stall lost");

  property p_stall_clr;
    @(posedge sys_clk) disable iff (!rst_n)
    (clr_stall && !stall_detect) |=> !stall_stop_event_flag;
  endproperty
  a_stall_clr: assert property (p_stall_clr) else $error("stall stuck");

  property p_release;
    @(posedge sys_clk) disable iff (!rst_n)
    (stall_stop_active && clr_stall && !stall_detect)
      |=> !stall_stop_active;
  endproperty
  a_release: assert property (p_release) else $error("no release");

  property p_irq;
    @(posedge sys_clk) disable iff (!rst_n)
    irq_out == (pos_arrival_event_flag | stall_stop_event_flag);
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");

  property p_lvl_drop;
    @(posedge sys_clk) disable iff (!rst_n)
    $past(current_motor_position != goal_position) |-> !position_reached;
  endproperty
  a_lvl_drop: assert property (p_lvl_drop) else $error("level stuck");

  c_arrive: cover property (@(posedge sys_clk) $rose(pos_arrival_event_flag));
  c_stall:  cover property (@(posedge sys_clk) $rose(stall_stop_active));
  c_rel:    cover property (@(posedge sys_clk) $fell(stall_stop_active));
  c_irq:    cover property (@(posedge sys_clk) $fell(irq_out));
endmodule : ramp_status_event_flags
`default_nettype wire

//--- verification/host_clear_model.sv
// Purpose: host side that writes ones to clear the event flags
// Assumes: requests come from the bench as one-cycle pulses
// Notes:   drives shortly after the rising edge, holds one cycle
`timescale 1ns/1ns
`default_nettype none
module host_clear_model (
  input  wire logic       sys_clk,
  input  wire logic [1:0] clear_req,
  output var  logic [1:0] event_clear
);
  initial event_clear = 2'h0; // no clear before the first write
  // write-one clear, one cycle per request
  always @(posedge sys_clk)
  begin
    event_clear <= #1 clear_req;
  end
endmodule : host_clear_model
`default_nettype wire

//--- verification/tb_top.sv
// Purpose: random and directed check of the ramp flag block
// Assumes: bench model updated on each rising edge
// Notes:   outputs compared with the model at every falling edge
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
  miscompares++; $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
  import ramp_flags_pkg::*;
  logic        sys_clk = 1'b0;        // 100 MHz clock
  logic        rst_n   = 1'b0;        // sync reset, low active
  logic [22:0] spd = 23'h0, mx = 23'h0;
  logic [31:0] pos = 32'h0, goal = 32'h1;
  logic        stall = 1'b0;          // stall detect request
  logic [1:0]  req = 2'h0, clr;       // clear request and host write
  logic        vr, pr, arr, st, stop, irq;
  logic        m_vr, m_pr, m_pold, m_arr, m_st; // bench model state
  logic [31:0] r = 32'h375BB8BE;      // xorshift state
  int          miscompares = 0, check_count = 0;
  bit          run = 0;               // compares start after first edge
  always #5 sys_clk = ~sys_clk;
  host_clear_model host_u (.sys_clk(sys_clk), .clear_req(req),
    .event_clear(clr));
  ramp_status_event_flags dut_u (.sys_clk(sys_clk), .rst_n(rst_n),
    .current_ramp_speed(spd), .max_ramp_speed(mx),
    .current_motor_position(pos), .goal_position(goal),
    .stall_detect(stall), .event_clear(clr), .velocity_reached(vr),
    .position_reached(pr), .pos_arrival_event_flag(arr),
    .stall_stop_event_flag(st), .stall_stop_active(stop), .irq_out(irq));
  // bench model: levels one cycle late, set wins over clear
  always @(posedge sys_clk)
  begin
    run <= 1;
    if (!rst_n)
      {m_vr, m_pr, m_pold, m_arr, m_st} <= 5'h0;
    else
    begin
      m_vr   <= (spd == mx);
      m_pr   <= (pos == goal);
      m_pold <= m_pr;
      m_arr  <= (m_pr & ~m_pold) | (m_arr & ~clr[0]);
      m_st   <= stall | (m_st & ~clr[1]);
    end
  end
  // compare every output with the model where all is settled
  always @(negedge sys_clk)
  begin
    if (run)
    begin
      `CHK(vr, m_vr)
      `CHK(pr, m_pr)
      `CHK(arr, m_arr)
      `CHK(st, m_st)
      `CHK(stop, m_st)
      `CHK(irq, m_arr | m_st)
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  // one cycle of stimulus, applied just after the rising edge
  task automatic drv(input int s, m, p, g, input bit sd, input int c);
    @(posedge sys_clk);
    #1;
    spd   = s[22:0];
    mx    = m[22:0];
    pos   = p;
    goal  = g;
    stall = sd;
    req   = c[1:0];
  endtask : drv
  task automatic conclude;
    $display("checks=%0d mismatches=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  // watchdog, far beyond the planned run of about 3030 cycles
  initial
  begin
    #200000;
    miscompares++;
    conclude();
  end
  initial
  begin
    repeat (6) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    // arrival event, then write-one clear, then equality lost
    drv(3, 3, 7, 7, 0, 0);
    repeat (4) drv(3, 3, 7, 7, 0, 0);
    drv(3, 3, 7, 7, 0, 1);
    drv(3, 3, 7, 7, 0, 0);
    drv(2, 3, 8, 7, 0, 0);
    repeat (3) drv(2, 3, 8, 7, 0, 0);
    $display("test arrival done");
    // stall: clear while detect is high is refused, then released
    drv(0, 1, 0, 1, 1, 2);
    drv(0, 1, 0, 1, 1, 2);
    drv(0, 1, 0, 1, 0, 0);
    drv(0, 1, 0, 1, 0, 2);
    drv(0, 1, 0, 1, 0, 3);
    repeat (3) drv(0, 1, 0, 1, 0, 0);
    $display("test stall done");
    // random traffic on small ranges so matches happen often
    repeat (3000)
    begin
      r = xs(r);
      drv(r[11:10], r[13:12], r[15:14], r[17:16], r[4:0] == 0,
          (r[9:7] == 0) ? r[6:5] : 0);
    end
    $display("test random done");
    // reset in mid-run with events set
    drv(0, 0, 1, 1, 1, 0);
    drv(0, 0, 1, 1, 0, 0);
    #1 rst_n = 1'b0;
    repeat (2) drv(0, 0, 1, 1, 0, 0);
    #1 rst_n = 1'b1;
    repeat (5) drv(0, 0, 1, 1, 0, 0);
    $display("test reset done");
    conclude();
  end
endmodule : tb_top
`default_nettype wire
